// >>> verilog/pmrs_defines.svh
// Register map, field positions, scale shifts, saturation values and timing of the scaler.
`ifndef PMRS_DEFINES_SVH
`define PMRS_DEFINES_SVH
`define PMRS_ADDR_CONFIG   8'h00
`define PMRS_ADDR_CAL      8'h04
`define PMRS_ADDR_SHUNT    8'h08
`define PMRS_ADDR_BUS      8'h0C
`define PMRS_ADDR_TEMP     8'h10
`define PMRS_ADDR_CURRENT  8'h14
`define PMRS_ADDR_POWER    8'h18
`define PMRS_ADDR_STATUS   8'h1C
`define PMRS_CFG_RANGE     0
`define PMRS_CFG_CT_LSB    1
`define PMRS_CFG_AVG_LSB   4
`define PMRS_CFG_RUN       7
`define PMRS_STAT_READY    0
`define PMRS_TEMP_LSB      4
`define PMRS_CLK_PERIOD_NS 20
`define PMRS_US_NS         1000
`define PMRS_US_CYCLES     (`PMRS_US_NS / `PMRS_CLK_PERIOD_NS)
`define PMRS_CT0_US        13'd50
`define PMRS_CT1_US        13'd84
`define PMRS_CT2_US        13'd150
`define PMRS_CT3_US        13'd280
`define PMRS_CT4_US        13'd540
`define PMRS_CT5_US        13'd1052
`define PMRS_CT6_US        13'd2074
`define PMRS_CT7_US        13'd4120
`define PMRS_AVG0_SH       4'h0
`define PMRS_AVG1_SH       4'h2
`define PMRS_AVG2_SH       4'h4
`define PMRS_AVG3_SH       4'h6
`define PMRS_AVG4_SH       4'h7
`define PMRS_AVG5_SH       4'h8
`define PMRS_AVG6_SH       4'h9
`define PMRS_AVG7_SH       4'hA
`define PMRS_CUR_SHIFT     11
`define PMRS_PWR_SHIFT     6
`define PMRS_CUR_POS_SAT   16'h7FFF
`define PMRS_CUR_NEG_SAT   16'h8000
`define PMRS_PWR_SAT       24'hFFFFFF
`endif

// >>> verilog/pmrs_pkg.sv
// Types shared by the result-scaling modules.
`default_nettype none
package pmrs_pkg;
	typedef enum logic [1:0] {SCL_IDLE, SCL_CUR, SCL_PWR} pmrs_scl_state_type;

	typedef struct packed {
		logic [26:0] acc;
		logic [10:0] cnt;
		logic [15:0] result;
		logic        done;
	} pmrs_avg_type;

	typedef struct packed {
		pmrs_scl_state_type state;
		logic [15:0]        shunt;
		logic [15:0]        bus;
		logic [15:0]        cal;
		logic [15:0]        current;
		logic [23:0]        power;
		logic               done;
	} pmrs_scl_type;

	typedef struct packed {
		logic        range;
		logic [2:0]  ct;
		logic [2:0]  avg;
		logic        run;
		logic [15:0] cal;
		logic        ready;
		logic        ap_valid;
		logic        ap_write;
		logic [7:0]  ap_addr;
		logic [31:0] rdata;
		logic        hready_o;
		logic        hresp_o;
		logic [5:0]  div_cnt;
		logic [12:0] us_cnt;
		logic        conv_start;
	} pmrs_top_type;
endpackage
`default_nettype wire

// >>> verilog/pmrs_averager.sv
// Digital averager: sums a power-of-two count of samples, then divides.
`default_nettype none
`include "pmrs_defines.svh"
module pmrs_averager
	import pmrs_pkg::*;
#(
	parameter bit SIGNED = 1'b1
)(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// Samples in
	input  wire logic        sample_valid,
	input  wire logic [15:0] sample,
	input  wire logic [3:0]  avg_shift,
	// Averaged result out
	output logic      [15:0] result,
	output logic             done
);
	pmrs_avg_type       s_r;
	pmrs_avg_type       s_nxt;
	logic signed [26:0] ext;
	logic signed [26:0] sum;
	logic signed [26:0] shifted;

	always_comb
	begin
		ext = SIGNED ? {{11{sample[15]}}, sample} : {11'h000, sample};
		sum = $signed(s_r.acc) + ext;
		shifted = sum >>> avg_shift;
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		if (sample_valid)
		begin
			if (s_r.cnt + 11'h001 >= (11'h001 << avg_shift))
			begin
				s_nxt.result = shifted[15:0];
				s_nxt.acc = '0;
				s_nxt.cnt = '0;
				s_nxt.done = 1'b1;
			end
			else
			begin
				s_nxt.acc = sum;
				s_nxt.cnt = s_r.cnt + 11'h001;
			end
		end
		if (!rst_b)
			s_nxt = '0;
	end

	always_ff @(posedge clk_sys)
	begin
		s_r <= s_nxt;
	end

	assign result = s_r.result;
	assign done = s_r.done;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	property p_avg_pass;
		sample_valid && avg_shift == `PMRS_AVG0_SH
			|=> done && result == $past(sample);
	endproperty
	a_avg_pass: assert property (p_avg_pass)
		else $error("Unaveraged sample not passed through.");
endmodule // pmrs_averager
`default_nettype wire

// >>> verilog/pmrs_scaler.sv
// Current and power calculation from shunt, bus and calibration values.
`default_nettype none
`include "pmrs_defines.svh"
module pmrs_scaler
	import pmrs_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// Measurement in
	input  wire logic        start,
	input  wire logic [15:0] shunt,
	input  wire logic [15:0] bus,
	input  wire logic [15:0] cal,
	// Results out
	output logic      [15:0] current,
	output logic      [23:0] power,
	output logic             done
);
	pmrs_scl_type       s_r;
	pmrs_scl_type       s_nxt;
	logic signed [32:0] prod;
	logic signed [32:0] scaled;
	logic [15:0]        mag;
	logic [31:0]        pprod;
	logic [31:0]        pscaled;

	always_comb
	begin
		prod = $signed(s_r.shunt) * $signed({1'b0, s_r.cal});
		scaled = prod >>> `PMRS_CUR_SHIFT;
		mag = s_r.current[15] ? 16'(-s_r.current) : s_r.current;
		pprod = mag * s_r.bus;
		pscaled = pprod >> `PMRS_PWR_SHIFT;
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		case (s_r.state)
			SCL_IDLE:
			begin
				if (start)
				begin
					s_nxt.shunt = shunt;
					s_nxt.bus = bus;
					s_nxt.cal = cal;
					s_nxt.state = SCL_CUR;
				end
			end
			SCL_CUR:
			begin
				if (s_r.cal == 16'h0000)
					s_nxt.current = '0;
				else if (scaled[32:15] != {18{scaled[15]}})
					s_nxt.current = scaled[32] ? `PMRS_CUR_NEG_SAT
						: `PMRS_CUR_POS_SAT;
				else
					s_nxt.current = scaled[15:0];
				s_nxt.state = SCL_PWR;
			end
			SCL_PWR:
			begin
				if (pscaled[31:24] != 8'h00)
					s_nxt.power = `PMRS_PWR_SAT;
				else
					s_nxt.power = pscaled[23:0];
				s_nxt.done = 1'b1;
				s_nxt.state = SCL_IDLE;
			end
			default:
				s_nxt.state = SCL_IDLE;
		endcase
		if (!rst_b)
			s_nxt = '0;
	end

	always_ff @(posedge clk_sys)
	begin
		s_r <= s_nxt;
	end

	assign current = s_r.current;
	assign power = s_r.power;
	assign done = s_r.done;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	sequence s_take;
		s_r.state == SCL_IDLE && start;
	endsequence
	sequence s_take_zero;
		s_r.state == SCL_IDLE && start && cal == 16'h0000;
	endsequence

	property p_latency;
		s_take |-> ##3 done;
	endproperty
	a_latency: assert property (p_latency)
		else $error("Current not recomputed three cycles after shunt.");

	property p_cal_zero;
		s_take_zero |-> ##2 (current == 16'h0000) ##1 done;
	endproperty
	a_cal_zero: assert property (p_cal_zero)
		else $error("Zero calibration gave nonzero current.");

	property p_sign;
		done && s_r.cal != 16'h0000 && !s_r.shunt[15]
			|-> !current[15];
	endproperty
	a_sign: assert property (p_sign)
		else $error("Current sign differs from shunt sign.");

	property p_power_zero;
		done && current == 16'h0000 |-> power == 24'h000000;
	endproperty
	a_power_zero: assert property (p_power_zero)
		else $error("Power nonzero with zero current.");
endmodule // pmrs_scaler
`default_nettype wire

// >>> verilog/pmrs_top.sv
// Result-scaling datapath of the power monitor with its AHB-Lite registers.
//
// Function
// - Range bit picks 5 or 1.25 uV steps.
// - Shunt result is 16-bit two's complement.
// - Bus result is unsigned, never negative.
// - Temperature is 12-bit signed, 125 mC steps.
// - Current recomputed after every shunt measurement; here after each averaged shunt result only.
// - Zero calibration forces current to zero.
// - Power result is 24-bit unsigned.
// - Selectable conversion time and averaging, 50 us least.
`default_nettype none
`include "pmrs_defines.svh"
module pmrs_top
	import pmrs_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic      [31:0] hrdata,
	output logic             hresp,
	// Converter results
	input  wire logic        adc_shunt_valid,
	input  wire logic [15:0] adc_shunt_code,
	input  wire logic        adc_bus_valid,
	input  wire logic [15:0] adc_bus_code,
	input  wire logic        adc_temp_valid,
	input  wire logic [11:0] adc_temp_code,
	// Converter control
	output logic             conv_start,
	output logic             shunt_range_select
);
	pmrs_top_type s_r;
	pmrs_top_type s_nxt;
	logic [3:0]   avg_sh;
	logic [15:0]  shunt_res;
	logic         shunt_done;
	logic [15:0]  bus_res;
	logic         bus_done;
	logic [15:0]  temp_res;
	logic         temp_done;
	logic [15:0]  cur_res;
	logic [23:0]  pwr_res;
	logic         scl_done;
	logic         ap_take;

	// ====================================================================
	// Decoders

	function automatic logic [12:0] ct_us(input logic [2:0] sel);
		case (sel)
			3'h0: ct_us = `PMRS_CT0_US;
			3'h1: ct_us = `PMRS_CT1_US;
			3'h2: ct_us = `PMRS_CT2_US;
			3'h3: ct_us = `PMRS_CT3_US;
			3'h4: ct_us = `PMRS_CT4_US;
			3'h5: ct_us = `PMRS_CT5_US;
			3'h6: ct_us = `PMRS_CT6_US;
			default: ct_us = `PMRS_CT7_US;
		endcase
	endfunction

	function automatic logic [3:0] avg_shift(input logic [2:0] sel);
		case (sel)
			3'h0: avg_shift = `PMRS_AVG0_SH;
			3'h1: avg_shift = `PMRS_AVG1_SH;
			3'h2: avg_shift = `PMRS_AVG2_SH;
			3'h3: avg_shift = `PMRS_AVG3_SH;
			3'h4: avg_shift = `PMRS_AVG4_SH;
			3'h5: avg_shift = `PMRS_AVG5_SH;
			3'h6: avg_shift = `PMRS_AVG6_SH;
			default: avg_shift = `PMRS_AVG7_SH;
		endcase
	endfunction

	function automatic logic [31:0] rd_mux(input logic [7:0] addr,
		input pmrs_top_type st, input logic [15:0] sh,
		input logic [15:0] bv, input logic [15:0] tp,
		input logic [15:0] cu, input logic [23:0] pw);
		if (addr == `PMRS_ADDR_CONFIG)
			rd_mux = {24'h000000, st.run, st.avg, st.ct, st.range};
		else if (addr == `PMRS_ADDR_CAL)
			rd_mux = {16'h0000, st.cal};
		else if (addr == `PMRS_ADDR_SHUNT)
			rd_mux = {{16{sh[15]}}, sh};
		else if (addr == `PMRS_ADDR_BUS)
			rd_mux = {16'h0000, bv};
		else if (addr == `PMRS_ADDR_TEMP)
			rd_mux = {{16{tp[11]}}, tp[11:0], 4'h0};
		else if (addr == `PMRS_ADDR_CURRENT)
			rd_mux = {{16{cu[15]}}, cu};
		else if (addr == `PMRS_ADDR_POWER)
			rd_mux = {8'h00, pw};
		else if (addr == `PMRS_ADDR_STATUS)
			rd_mux = {31'h00000000, st.ready};
		else
			rd_mux = 32'h00000000;
	endfunction

	// ====================================================================
	// Averagers and scaler

	assign avg_sh = avg_shift(s_r.avg);

	pmrs_averager #(
		.SIGNED (1'b1)
	) u_avg_shunt (
		.clk_sys      (clk_sys),
		.rst_b        (rst_b),
		.sample_valid (adc_shunt_valid),
		.sample       (adc_shunt_code),
		.avg_shift    (avg_sh),
		.result       (shunt_res),
		.done         (shunt_done)
	);

	pmrs_averager #(
		.SIGNED (1'b0)
	) u_avg_bus (
		.clk_sys      (clk_sys),
		.rst_b        (rst_b),
		.sample_valid (adc_bus_valid),
		.sample       (adc_bus_code),
		.avg_shift    (avg_sh),
		.result       (bus_res),
		.done         (bus_done)
	);

	pmrs_averager #(
		.SIGNED (1'b1)
	) u_avg_temp (
		.clk_sys      (clk_sys),
		.rst_b        (rst_b),
		.sample_valid (adc_temp_valid),
		.sample       ({{4{adc_temp_code[11]}}, adc_temp_code}),
		.avg_shift    (avg_sh),
		.result       (temp_res),
		.done         (temp_done)
	);

	pmrs_scaler u_scaler (
		.clk_sys (clk_sys),
		.rst_b   (rst_b),
		.start   (shunt_done),
		.shunt   (shunt_res),
		.bus     (bus_res),
		.cal     (s_r.cal),
		.current (cur_res),
		.power   (pwr_res),
		.done    (scl_done)
	);

	// ====================================================================
	// Registers, bus slave and conversion timer

	assign ap_take = hsel && htrans[1] && hready;

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.conv_start = 1'b0;
		s_nxt.hready_o = 1'b1;
		s_nxt.hresp_o = 1'b0;
		// Write data phase of the previous address phase.
		if (s_r.ap_valid && s_r.ap_write)
		begin
			if (s_r.ap_addr == `PMRS_ADDR_CONFIG)
			begin
				s_nxt.range = hwdata[`PMRS_CFG_RANGE];
				s_nxt.ct = hwdata[`PMRS_CFG_CT_LSB +: 3];
				s_nxt.avg = hwdata[`PMRS_CFG_AVG_LSB +: 3];
				s_nxt.run = hwdata[`PMRS_CFG_RUN];
			end
			else if (s_r.ap_addr == `PMRS_ADDR_CAL)
				s_nxt.cal = hwdata[15:0];
		end
		s_nxt.ap_valid = ap_take;
		s_nxt.ap_write = hwrite;
		s_nxt.ap_addr = haddr[7:0];
		if (ap_take && !hwrite)
			s_nxt.rdata = rd_mux(haddr[7:0], s_r, shunt_res, bus_res,
				temp_res, cur_res, pwr_res);
		// Reading status clears ready; a new result in that cycle wins.
		if (ap_take && !hwrite && haddr[7:0] == `PMRS_ADDR_STATUS)
			s_nxt.ready = 1'b0;
		if (scl_done)
			s_nxt.ready = 1'b1;
		if (!s_r.run)
		begin
			s_nxt.div_cnt = '0;
			s_nxt.us_cnt = '0;
		end
		else if (s_r.div_cnt == 6'(`PMRS_US_CYCLES - 1))
		begin
			s_nxt.div_cnt = '0;
			if (s_r.us_cnt == ct_us(s_r.ct) - 13'd1)
			begin
				s_nxt.us_cnt = '0;
				s_nxt.conv_start = 1'b1;
			end
			else
				s_nxt.us_cnt = s_r.us_cnt + 13'd1;
		end
		else
			s_nxt.div_cnt = s_r.div_cnt + 6'd1;
		if (!rst_b)
		begin
			s_nxt = '0;
			s_nxt.hready_o = 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		s_r <= s_nxt;
	end

	assign hreadyout = s_r.hready_o;
	assign hrdata = s_r.rdata;
	assign hresp = s_r.hresp_o;
	assign conv_start = s_r.conv_start;
	assign shunt_range_select = s_r.range;

	// ====================================================================
	// Checks

	logic [15:0] gap_r;

	always_ff @(posedge clk_sys)
	begin
		if (!rst_b)
			gap_r <= 16'hFFFF;
		else if (conv_start)
			gap_r <= 16'h0001;
		else if (gap_r != 16'hFFFF)
			gap_r <= gap_r + 16'h0001;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	property p_range;
		s_r.ap_valid && s_r.ap_write && s_r.ap_addr == `PMRS_ADDR_CONFIG
			|=> shunt_range_select == $past(hwdata[`PMRS_CFG_RANGE]);
	endproperty
	a_range: assert property (p_range)
		else $error("Range select not taken from config write.");

	property p_shunt;
		s_r.ap_valid && !s_r.ap_write && s_r.ap_addr == `PMRS_ADDR_SHUNT
			|-> hrdata[31:16] == {16{hrdata[15]}}
			&& hrdata[15:0] == $past(shunt_res);
	endproperty
	a_shunt: assert property (p_shunt)
		else $error("Shunt result not sign-extended.");

	property p_bus;
		s_r.ap_valid && !s_r.ap_write && s_r.ap_addr == `PMRS_ADDR_BUS
			|-> hrdata[31:16] == 16'h0000;
	endproperty
	a_bus: assert property (p_bus)
		else $error("Bus result read back negative.");

	property p_temp;
		s_r.ap_valid && !s_r.ap_write && s_r.ap_addr == `PMRS_ADDR_TEMP
			|-> hrdata[3:0] == 4'h0 && hrdata[31:16] == {16{hrdata[15]}};
	endproperty
	a_temp: assert property (p_temp)
		else $error("Temperature field misplaced or not sign-extended.");

	property p_conv_gap;
		conv_start |-> gap_r >= (`PMRS_CT0_US * `PMRS_US_CYCLES);
	endproperty
	a_conv_gap: assert property (p_conv_gap)
		else $error("Conversion started sooner than the least time.");

	property p_ready;
		scl_done |=> s_r.ready;
	endproperty
	a_ready: assert property (p_ready)
		else $error("New current result did not raise ready.");
endmodule // pmrs_top
`default_nettype wire

// >>> tb/pmrs_top_test.sv
// Self-checking testbench for the result-scaling datapath and its registers.
`default_nettype none
`include "pmrs_defines.svh"
module pmrs_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import pmrs_pkg::*;

	// ==========================================================
	// Signals
	logic        clk_sys;
	logic        rst_b;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	wire logic   hready;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic        sh_v;
	logic [15:0] sh_c;
	logic        bu_v;
	logic [15:0] bu_c;
	logic        tp_v;
	logic [11:0] tp_c;
	logic        conv_start;
	logic        shunt_range_select;
	int          num_errors;
	int          n_checks;
	int          n;
	logic [31:0] e_cur;
	int          n_exp;

	assign hready = hreadyout;

	pmrs_top pmrs_top_i (
		.clk_sys(clk_sys), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hrdata(hrdata), .hresp(hresp), .adc_shunt_valid(sh_v),
		.adc_shunt_code(sh_c), .adc_bus_valid(bu_v),
		.adc_bus_code(bu_c), .adc_temp_valid(tp_v),
		.adc_temp_code(tp_c), .conv_start(conv_start),
		.shunt_range_select(shunt_range_select)
	);

	// ==========================================================
	// Clock, verdict and watchdog
	initial
	begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	task automatic conclude();
		$display("Comparisons %0d, mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		num_errors++;
		conclude();
	end

	// ==========================================================
	// Bus, converter and compare tasks
	task automatic check32(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= 1'b1;
		do @(posedge clk_sys); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_sys); while (hready !== 1'b1);
	endtask

	task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h000000, a};
		htrans <= 2'b10;
		hwrite <= 1'b0;
		do @(posedge clk_sys); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		do @(posedge clk_sys); while (hready !== 1'b1);
		d = hrdata;
	endtask

	task automatic check_reg(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		bus_read(a, d);
		check32(d, exp);
	endtask

	// Kind 0 shunt, 1 bus, 2 temperature; samples stay 5 cycles apart.
	task automatic sample(input int kind, input logic [15:0] code);
		if (kind == 0)
		begin
			sh_v <= 1'b1;
			sh_c <= code;
		end
		else if (kind == 1)
		begin
			bu_v <= 1'b1;
			bu_c <= code;
		end
		else
		begin
			tp_v <= 1'b1;
			tp_c <= code[11:0];
		end
		@(posedge clk_sys);
		sh_v <= 1'b0;
		bu_v <= 1'b0;
		tp_v <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask

	function automatic logic [31:0] exp_cur(input logic [15:0] s,
		input logic [15:0] c);
		longint p;
		p = (longint'($signed(s)) * longint'(c)) >>> 11;
		if (p > 32767)
			p = 32767;
		if (p < -32768)
			p = -32768;
		return p[31:0];
	endfunction

	function automatic logic [31:0] exp_pwr(input logic [31:0] cur,
		input logic [15:0] b);
		longint a;
		a = longint'($signed(cur));
		if (a < 0)
			a = -a;
		a = (a * longint'(b)) >> 6;
		if (a > 64'sh0FFFFFF)
			a = 64'sh0FFFFFF;
		return a[31:0];
	endfunction

	// ==========================================================
	// Tests
	logic [15:0] t_sh [5] = '{16'h1000, 16'hF000, 16'h7FFF, 16'h8000,
		16'h1234};
	logic [15:0] t_cal [5] = '{16'h0800, 16'h0800, 16'hFFFF, 16'hFFFF,
		16'h0000};
	logic [15:0] t_bus [5] = '{16'h4000, 16'h4000, 16'hFFFF, 16'h0040,
		16'h2000};

	initial
	begin
		num_errors = 0;
		n_checks = 0;
		rst_b = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h00000000;
		sh_v = 1'b0;
		sh_c = 16'h0000;
		bu_v = 1'b0;
		bu_c = 16'h0000;
		tp_v = 1'b0;
		tp_c = 12'h000;
		repeat (12) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		check32({30'h0, hreadyout, hresp}, 32'h00000002);
		check_reg(`PMRS_ADDR_CONFIG, 32'h00000000);
		check_reg(`PMRS_ADDR_CURRENT, 32'h00000000);
		check_reg(8'h20, 32'h00000000);
		bus_write(`PMRS_ADDR_CONFIG, 32'h00000001);
		@(posedge clk_sys);
		check32({31'h0, shunt_range_select}, 32'h00000001);
		check_reg(`PMRS_ADDR_CONFIG, 32'h00000001);
		bus_write(`PMRS_ADDR_CONFIG, 32'h00000000);
		@(posedge clk_sys);
		check32({31'h0, shunt_range_select}, 32'h00000000);
		for (int i = 0; i < 5; i++)
		begin
			bus_write(`PMRS_ADDR_CAL, {16'h0000, t_cal[i]});
			sample(1, t_bus[i]);
			sample(0, t_sh[i]);
			repeat (6) @(posedge clk_sys);
			e_cur = exp_cur(t_sh[i], t_cal[i]);
			check_reg(`PMRS_ADDR_SHUNT, 32'($signed(t_sh[i])));
			check_reg(`PMRS_ADDR_BUS, {16'h0000, t_bus[i]});
			check_reg(`PMRS_ADDR_CURRENT, e_cur);
			check_reg(`PMRS_ADDR_POWER, exp_pwr(e_cur, t_bus[i]));
			check_reg(`PMRS_ADDR_STATUS, 32'h00000001);
			check_reg(`PMRS_ADDR_STATUS, 32'h00000000);
		end
		check_reg(`PMRS_ADDR_CURRENT, 32'h00000000);
		bus_write(`PMRS_ADDR_CONFIG, 32'h00000001);
		bus_write(`PMRS_ADDR_CAL, {16'h0000, 16'h0100 << 2});
		sample(1, 16'h4000);
		sample(0, 16'hE000);
		repeat (6) @(posedge clk_sys);
		e_cur = exp_cur(16'hE000, 16'h0400);
		check_reg(`PMRS_ADDR_CURRENT, e_cur);
		check_reg(`PMRS_ADDR_POWER, exp_pwr(e_cur, 16'h4000));
		sample(2, 16'h0800);
		check_reg(`PMRS_ADDR_TEMP, 32'hFFFF8000);
		sample(2, 16'h07FF);
		check_reg(`PMRS_ADDR_TEMP, 32'h00007FF0);
		bus_write(`PMRS_ADDR_CONFIG, 32'h00000010);
		sample(0, 16'd100);
		sample(0, 16'd101);
		sample(0, 16'd102);
		sample(0, 16'd104);
		check_reg(`PMRS_ADDR_SHUNT, 32'd101);
		sample(0, 16'hFFFD);
		sample(0, 16'hFFFE);
		sample(0, 16'hFFFE);
		sample(0, 16'hFFFE);
		check_reg(`PMRS_ADDR_SHUNT, 32'hFFFFFFFD);
		for (int k = 0; k < 2; k++)
		begin
			n_exp = (k == 0) ? `PMRS_CT0_US * `PMRS_US_CYCLES
				: `PMRS_CT1_US * `PMRS_US_CYCLES;
			bus_write(`PMRS_ADDR_CONFIG, (k == 0) ? 32'h00000080
				: 32'h00000082);
			n = 0;
			while (conv_start !== 1'b1 && n < 5000)
			begin
				@(posedge clk_sys);
				n++;
			end
			n = n - n_exp;
			check32(32'(n >= -5 && n <= 5), 32'h00000001);
			@(posedge clk_sys);
			check32({31'h0, conv_start}, 32'h00000000);
			bus_write(`PMRS_ADDR_CONFIG, 32'h00000000);
		end
		conclude();
	end
endmodule // pmrs_top_test
`default_nettype wire
